/* core/dcf_pkg.sv */
// Constants shared by the first-in first-out buffer with programmable flags.
// Assumes one 100 MHz system clock; every other timing is counted in its cycles.
package dcf_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int unsigned DATA_W      = 18;     // Word width.
  localparam int unsigned DEPTH_DEF   = 8192;   // Buffer depth, 8192 or 16384.
  localparam int unsigned OFS_W       = 14;     // Offset register width.
  localparam int unsigned STAGE_DEPTH = 8;      // Words in the write staging buffer.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [13:0] OFS_RST  = 14'h007F;  // Default distance for both offsets.
  localparam logic [17:0] DOUT_RST = 18'h0_0000; // Output register after reset.

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned REWIND_RECOVERY_NS   = 10;
  localparam int unsigned REWIND_RECOVERY_RAW  =
    (REWIND_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REWIND_RECOVERY_CYC  =
    (REWIND_RECOVERY_RAW < 1) ? 1 : REWIND_RECOVERY_RAW;
  localparam logic [7:0]  RECOVERY_CNT_INIT    = 8'(REWIND_RECOVERY_CYC);

  // ****************************************************************
  // Offset register selection sequence
  // ****************************************************************
  typedef enum logic [1:0] {
    DCF_SEL_EMPTY = 2'b01,
    DCF_SEL_FULL  = 2'b10
  } dcf_sel_e;

endpackage

/* core/dcf_fifo.sv */
// Buffer of words with programmable almost-empty and almost-full flags.
// Assumes write and read strobes arrive as levels synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Staging buffer between the write port and the main array
// ****************************************************************
module dcf_stage_fifo #(
  parameter int unsigned WIDTH = dcf_pkg::DATA_W,
  parameter int unsigned DEPTH = dcf_pkg::STAGE_DEPTH
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]    count_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("Staging depth must be a power of two of at least 2.");
  end

  logic [WIDTH-1:0]            store [DEPTH];
  logic [PW:0]                 head_reg;
  logic [PW:0]                 tail_reg;
  wire logic                   push;
  wire logic                   pop;
  wire logic [PW:0]            fill;

  // Full and empty follow the pointer difference with one wrap bit.
  assign fill        = tail_reg - head_reg;
  assign in_ready_o  = (fill != (PW+1)'(DEPTH));
  assign out_valid_o = (fill != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = store[head_reg[PW-1:0]];
  assign count_o     = ($clog2(DEPTH+1))'(fill);

  // Pointers move on accepted transfers only.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (push) tail_reg <= tail_reg + 1'b1;
      if (pop) head_reg <= head_reg + 1'b1;
    end
  end

  // Storage carries no reset; only written words are ever read.
  always_ff @(posedge clk_sys_i) begin
    if (push) store[tail_reg[PW-1:0]] <= in_data_i;
  end
endmodule

// ****************************************************************
// Buffer core
// ****************************************************************
module dcf_fifo #(
  parameter int unsigned DATA_W = dcf_pkg::DATA_W,
  parameter int unsigned DEPTH  = dcf_pkg::DEPTH_DEF,
  parameter int unsigned OFS_W  = dcf_pkg::OFS_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_clk_i,
  input  wire logic              rd_clk_i,
  input  wire logic              wr_en_n_i,
  input  wire logic              rd_en_n_i,
  input  wire logic              out_en_n_i,
  input  wire logic              offset_load_n_i,
  input  wire logic              sync_flag_sel_n_i,
  input  wire logic              rewind_pulse_i,
  input  wire logic              cascaded_i,
  input  wire logic              cascade_rd_in_n_i,
  input  wire logic [DATA_W-1:0] din_i,
  output logic [DATA_W-1:0]      dout_o,
  output logic                   dout_oe_o,
  output logic                   empty_n_o,
  output logic                   full_n_o,
  output logic                   half_full_n_o,
  output logic                   almost_empty_n_o,
  output logic                   almost_full_n_o,
  output logic                   wr_ready_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 2;
  localparam int unsigned SW = $clog2(dcf_pkg::STAGE_DEPTH + 1);

  // Pointer wrap needs a power-of-two depth, and the offsets are loaded from and
  // read back over the low data bits, so the data path must be at least that wide.
  if ((1 << AW) != DEPTH || DATA_W < OFS_W || OFS_W > CW) begin : g_chk
    $error("Depth must be a power of two and data must cover the offsets.");
  end

  logic [DATA_W-1:0]       mem [DEPTH];
  logic [AW:0]             wptr_reg;
  logic [AW:0]             rptr_reg;
  logic [DATA_W-1:0]       dout_reg;
  logic [OFS_W-1:0]        ae_ofs_reg;
  logic [OFS_W-1:0]        af_ofs_reg;
  dcf_pkg::dcf_sel_e       wsel_reg;
  dcf_pkg::dcf_sel_e       rsel_reg;
  logic                    wclk_q_reg;
  logic                    rclk_q_reg;
  logic                    empty_n_reg;
  logic                    full_n_reg;
  logic                    ae_n_reg;
  logic                    af_n_reg;
  logic [7:0]              recov_reg;
  logic [7:0]              recov_next;

  wire logic               wr_edge;
  wire logic               rd_edge;
  wire logic               quiet;
  wire logic               rewind;
  wire logic               prog_wr;
  wire logic               prog_rd;
  wire logic               data_wr;
  wire logic               data_rd;
  wire logic               stage_valid;
  wire logic               drain_ready;
  wire logic [DATA_W-1:0]  stage_data;
  wire logic [SW-1:0]      stage_cnt;
  wire logic [AW:0]        main_cnt;
  wire logic [CW-1:0]      total_cnt;
  wire logic [CW-1:0]      depth_c;
  wire logic               empty_c;
  wire logic               full_c;
  wire logic               ae_c;
  wire logic               af_c;
  wire logic               hf_c;
  wire logic [OFS_W-1:0]   ofs_rd_word;
  // Counts and flag values as they will stand once this cycle's transfers land.
  wire logic               drain_fire;
  wire logic [AW:0]        rd_cnt_next;
  wire logic [CW-1:0]      wr_cnt_next;
  wire logic               empty_nx_c;
  wire logic               full_nx_c;
  wire logic               ae_nx_c;
  wire logic               af_nx_c;

  // ****************************************************************
  // Strobe decode and transfer qualification
  // ****************************************************************
  // Strobe edges and qualified operations; no data or offset read or write acts during rewind recovery.
  assign wr_edge  = wr_clk_i & ~wclk_q_reg;
  assign rd_edge  = rd_clk_i & ~rclk_q_reg;
  assign quiet    = (recov_reg == '0);
  assign rewind   = rewind_pulse_i & ~cascaded_i;
  assign prog_wr  = wr_edge & ~wr_en_n_i & ~offset_load_n_i & quiet;
  assign prog_rd  = rd_edge & ~rd_en_n_i & ~offset_load_n_i & quiet;
  assign data_wr  = wr_edge & ~wr_en_n_i & offset_load_n_i & quiet
                    & full_n_reg & ~full_c;
  // A read also checks the live count, a second guard against an unwritten location.
  assign data_rd  = rd_edge & ~rd_en_n_i & ~out_en_n_i & offset_load_n_i
                    & quiet & empty_n_reg & ~empty_c;
  assign ofs_rd_word = (rsel_reg == dcf_pkg::DCF_SEL_EMPTY) ? ae_ofs_reg : af_ofs_reg;

  // ****************************************************************
  // Word counts and flags
  // ****************************************************************
  // Counts from pointer difference plus words still staged.
  assign main_cnt    = wptr_reg - rptr_reg;
  assign total_cnt   = CW'(main_cnt) + CW'(stage_cnt);
  assign depth_c     = CW'(DEPTH);
  assign drain_ready = (main_cnt != (AW+1)'(DEPTH));
  assign wr_ready_o  = ~full_c;

  // Flag decode from the word counts.
  assign empty_c = (main_cnt == '0);
  assign full_c  = (total_cnt >= depth_c);
  assign hf_c    = (total_cnt > (depth_c >> 1));
  assign ae_c    = (CW'(main_cnt) <= CW'(ae_ofs_reg));
  assign af_c    = (total_cnt >= (depth_c - CW'(af_ofs_reg)));

  // Registered flags take the counts after this edge's own transfer. Taking the
  // counts before it would leave each flag one strobe behind: the last word read
  // would leave the empty flag high over an empty array, and the word that fills
  // the array would leave the full flag high.
  assign drain_fire  = stage_valid & drain_ready;
  assign rd_cnt_next = main_cnt + (AW+1)'(drain_fire) - (AW+1)'(data_rd);
  assign wr_cnt_next = total_cnt + CW'(data_wr) - CW'(data_rd);
  assign empty_nx_c  = (rd_cnt_next == '0);
  assign full_nx_c   = (wr_cnt_next >= depth_c);
  assign ae_nx_c     = (CW'(rd_cnt_next) <= CW'(ae_ofs_reg));
  assign af_nx_c     = (wr_cnt_next >= (depth_c - CW'(af_ofs_reg)));

  // Output drivers and flag selection between synchronous and free-running forms.
  assign dout_o           = dout_reg;
  assign dout_oe_o        = ~out_en_n_i & (~cascaded_i | ~cascade_rd_in_n_i);
  assign empty_n_o        = empty_n_reg;
  assign full_n_o         = full_n_reg;
  assign half_full_n_o    = ~hf_c;
  assign almost_empty_n_o = sync_flag_sel_n_i ? ~ae_c : ae_n_reg;
  assign almost_full_n_o  = sync_flag_sel_n_i ? ~af_c : af_n_reg;

  // Write staging holds accepted words until the main array takes them.
  // Its count joins the full and almost-full decode, so a word accepted here is
  // already counted against the depth and no write can outrun the array.
  dcf_stage_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (dcf_pkg::STAGE_DEPTH)
  ) u_stage (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (data_wr),
    .in_ready_o  (),
    .in_data_i   (din_i),
    .out_valid_o (stage_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (stage_data),
    .count_o     (stage_cnt)
  );

  // Recovery timer restarts on every rewind cycle.
  // A rewind held high for several cycles therefore stretches the quiet time.
  always_comb begin
    recov_next = recov_reg;
    if (rewind) begin
      recov_next = dcf_pkg::RECOVERY_CNT_INIT;
    end else if (recov_reg != '0) begin
      recov_next = recov_reg - 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Pointers, edge history and recovery timer.
  // Strobe history resets low, the idle level of both strobes, so an idle strobe
  // never shows a false edge just after reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg   <= '0;
      rptr_reg   <= '0;
      wclk_q_reg <= 1'b0;
      rclk_q_reg <= 1'b0;
      recov_reg  <= '0;
    end else begin
      wclk_q_reg <= wr_clk_i;
      rclk_q_reg <= rd_clk_i;
      recov_reg  <= recov_next;
      if (drain_fire) wptr_reg <= wptr_reg + 1'b1;
      if (rewind) begin
        rptr_reg <= '0;
      end else if (data_rd) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

  // Output register keeps the last word when reads are refused.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_reg <= dcf_pkg::DOUT_RST;
    end else if (data_rd) begin
      dout_reg <= mem[rptr_reg[AW-1:0]];
    end else if (prog_rd) begin
      dout_reg <= DATA_W'(ofs_rd_word);
    end
  end

  // Offset registers and their alternating selectors.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ae_ofs_reg <= OFS_W'(dcf_pkg::OFS_RST);
      af_ofs_reg <= OFS_W'(dcf_pkg::OFS_RST);
      wsel_reg   <= dcf_pkg::DCF_SEL_EMPTY;
      rsel_reg   <= dcf_pkg::DCF_SEL_EMPTY;
    end else begin
      if (prog_wr) begin
        case (wsel_reg)
          dcf_pkg::DCF_SEL_EMPTY: begin
            ae_ofs_reg <= din_i[OFS_W-1:0];
            wsel_reg   <= dcf_pkg::DCF_SEL_FULL;
          end
          dcf_pkg::DCF_SEL_FULL: begin
            af_ofs_reg <= din_i[OFS_W-1:0];
            wsel_reg   <= dcf_pkg::DCF_SEL_EMPTY;
          end
          default: wsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        endcase
      end
      if (prog_rd) begin
        case (rsel_reg)
          dcf_pkg::DCF_SEL_EMPTY: rsel_reg <= dcf_pkg::DCF_SEL_FULL;
          dcf_pkg::DCF_SEL_FULL:  rsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
          default:                rsel_reg <= dcf_pkg::DCF_SEL_EMPTY;
        endcase
      end
    end
  end

  // Boundary flags refresh on their own edges; almost flags wait out recovery.
  // Each registered flag moves only on its own strobe edge, never on the far side's.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      empty_n_reg <= 1'b0;
      full_n_reg  <= 1'b1;
      ae_n_reg    <= 1'b0;
      af_n_reg    <= 1'b1;
    end else begin
      if (rd_edge) empty_n_reg <= ~empty_nx_c;
      if (wr_edge) full_n_reg <= ~full_nx_c;
      if (rd_edge & quiet) ae_n_reg <= ~ae_nx_c;
      if (wr_edge & quiet) af_n_reg <= ~af_nx_c;
    end
  end

  // Main array write from the staging buffer.
  always_ff @(posedge clk_sys_i) begin
    if (drain_fire) mem[wptr_reg[AW-1:0]] <= stage_data;
  end
endmodule

`default_nettype wire

/* tb/dcf_fifo_monitor.sv */
// Checker for flag, output and drive timing of the buffer.
// Assumes it is bound to dcf_fifo and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_monitor #(parameter int unsigned DATA_W = 18) (
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic              wr_clk_i,
  input wire logic              rd_clk_i,
  input wire logic              out_en_n_i,
  input wire logic              offset_load_n_i,
  input wire logic              sync_flag_sel_n_i,
  input wire logic              cascaded_i,
  input wire logic              cascade_rd_in_n_i,
  input wire logic [DATA_W-1:0] dout_o,
  input wire logic              dout_oe_o,
  input wire logic              empty_n_o,
  input wire logic              full_n_o,
  input wire logic              half_full_n_o,
  input wire logic              almost_empty_n_o,
  input wire logic              almost_full_n_o
);
  // ******
  // Strobe edge detection, matching how the design samples its strobes.
  // ******
  logic      wr_q;
  logic      rd_q;
  wire logic wr_edge = wr_clk_i & ~wr_q;
  wire logic rd_edge = rd_clk_i & ~rd_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= wr_clk_i;
      rd_q <= rd_clk_i;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Flags and outputs leave reset in the empty state.
  rst_state_a: assert property ($rose(rst_n_i) |-> !empty_n_o && full_n_o
    && half_full_n_o && dout_o == '0) else $error("state wrong after reset");
  drive_enable_a: assert property (dout_oe_o == (!out_en_n_i
    && (!cascaded_i || !cascade_rd_in_n_i))) else $error("output drive enable wrong");
  full_on_wr_a: assert property ($changed(full_n_o) |-> $past(wr_edge))
    else $error("full flag moved without a write edge");
  empty_on_rd_a: assert property ($changed(empty_n_o) |-> $past(rd_edge))
    else $error("empty flag moved without a read edge");
  empty_hold_a: assert property (rd_edge && !empty_n_o && offset_load_n_i
    |=> $stable(dout_o)) else $error("output changed on a read while empty");
  read_needs_oe_a: assert property (rd_edge && out_en_n_i && offset_load_n_i
    |=> $stable(dout_o)) else $error("read taken with output enable high");
  dout_cause_a: assert property ($changed(dout_o) |-> $past(rd_edge))
    else $error("output changed without a read edge");
  ae_sync_a: assert property (!sync_flag_sel_n_i && $past(!sync_flag_sel_n_i)
    && $changed(almost_empty_n_o) |-> $past(rd_edge)) else $error("almost empty off edge");
  af_sync_a: assert property (!sync_flag_sel_n_i && $past(!sync_flag_sel_n_i)
    && $changed(almost_full_n_o) |-> $past(wr_edge)) else $error("almost full off edge");
  // Main scenarios reached.
  cover property (rd_edge && !offset_load_n_i);
  cover property ($fell(full_n_o));
  cover property (!sync_flag_sel_n_i && $fell(almost_empty_n_o));
endmodule
bind dcf_fifo dcf_fifo_monitor #(.DATA_W(DATA_W)) dcf_fifo_monitor_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_clk_i(wr_clk_i), .rd_clk_i(rd_clk_i),
  .out_en_n_i(out_en_n_i), .offset_load_n_i(offset_load_n_i), .dout_o(dout_o),
  .sync_flag_sel_n_i(sync_flag_sel_n_i), .cascaded_i(cascaded_i), .dout_oe_o(dout_oe_o),
  .cascade_rd_in_n_i(cascade_rd_in_n_i), .empty_n_o(empty_n_o), .full_n_o(full_n_o),
  .half_full_n_o(half_full_n_o), .almost_empty_n_o(almost_empty_n_o),
  .almost_full_n_o(almost_full_n_o));
`default_nettype wire

/* tb/dcf_peer.sv */
// Producer and consumer model strobing the write and read ports.
// Assumes every change lands 1 ns after a rising edge of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module dcf_peer (
  input  wire logic        clk_sys_i,
  input  wire logic        empty_n_i,
  output logic             wr_clk_o,
  output logic             wr_en_n_o,
  output logic             rd_clk_o,
  output logic             rd_en_n_o,
  output logic             offset_load_n_o,
  output logic [17:0]      din_o
);
  // Idle with strobes low and enables off.
  initial begin
    {wr_clk_o, rd_clk_o} = 2'b00;
    {wr_en_n_o, rd_en_n_o, offset_load_n_o} = 3'b111;
    din_o = 18'h0_0000;
  end
  // One write strobe; released data is inverted so a stale word never passes.
  task automatic put(input logic [17:0] d, input logic ld_n);
    @(posedge clk_sys_i) #1;
    {wr_clk_o, wr_en_n_o, offset_load_n_o, din_o} = {2'b10, ld_n, d};
    @(posedge clk_sys_i) #1;
    {wr_clk_o, wr_en_n_o, offset_load_n_o, din_o} = {3'b011, ~d};
  endtask
  // One read strobe, data or offset according to ld_n.
  task automatic strobe_rd(input logic ld_n);
    @(posedge clk_sys_i) #1;
    {rd_clk_o, rd_en_n_o, offset_load_n_o} = {2'b10, ld_n};
    @(posedge clk_sys_i) #1;
    {rd_clk_o, rd_en_n_o, offset_load_n_o} = 3'b011;
  endtask
  // A stale empty flag only moves on a read edge, so refresh it first.
  task automatic take(input logic ld_n);
    if (ld_n && !empty_n_i) strobe_rd(ld_n);
    strobe_rd(ld_n);
  endtask
endmodule
`default_nettype wire

/* tb/dcf_fifo_tb.sv */
// Self-checking bench for dcf_fifo driven through the dcf_peer model.
// Assumes the package, design files, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_tb;
  localparam int unsigned DEP = dcf_pkg::DEPTH_DEF;
  typedef struct { logic [17:0] d; logic ae; } dcf_row_s;
  logic        clk_sys_i, rst_n_i;
  logic [4:0]  mode;
  wire logic   out_en_n_i, sync_flag_sel_n_i, rewind_pulse_i, cascaded_i, cascade_rd_in_n_i;
  wire logic   wr_clk, rd_clk, wr_en_n, rd_en_n, ld_n, oe, empty_n, full_n;
  wire logic   half_n, ae_n, af_n, wr_ready;
  wire logic [17:0] din, dout;
  int          n_fail, cmp_count;
  dcf_row_s    rows [4] = '{'{18'h0_0011, 1'b0}, '{18'h3_FFFF, 1'b0},
                            '{18'h2_AAAA, 1'b0}, '{18'h1_5555, 1'b1}};
  logic [2:0]  ens [4] = '{3'b100, 3'b011, 3'b010, 3'b000};
  // Mode bits: 4 output enable, 3 flag timing, 2 rewind, 1 cascade, 0 read token.
  assign {out_en_n_i, sync_flag_sel_n_i, rewind_pulse_i, cascaded_i, cascade_rd_in_n_i} = mode;
  dcf_fifo dcf_fifo_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_clk_i(wr_clk),
    .rd_clk_i(rd_clk), .wr_en_n_i(wr_en_n), .rd_en_n_i(rd_en_n), .out_en_n_i(out_en_n_i),
    .offset_load_n_i(ld_n), .sync_flag_sel_n_i(sync_flag_sel_n_i), .din_i(din),
    .rewind_pulse_i(rewind_pulse_i), .cascaded_i(cascaded_i), .dout_o(dout),
    .cascade_rd_in_n_i(cascade_rd_in_n_i), .dout_oe_o(oe), .empty_n_o(empty_n),
    .full_n_o(full_n), .half_full_n_o(half_n), .almost_empty_n_o(ae_n),
    .almost_full_n_o(af_n), .wr_ready_o(wr_ready));
  dcf_peer dcf_peer_inst (.clk_sys_i(clk_sys_i), .empty_n_i(empty_n), .wr_clk_o(wr_clk),
    .wr_en_n_o(wr_en_n), .rd_clk_o(rd_clk), .rd_en_n_o(rd_en_n), .offset_load_n_o(ld_n),
    .din_o(din));
  // ******
  // Clock and helper tasks.
  // ******
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  // No access is made while reset is low.
  task automatic do_reset();
    rst_n_i = 1'b0;
    cyc(20);
    rst_n_i = 1'b1;
  endtask
  // Accesses stay off through the pulse and its recovery.
  task automatic rewind();
    mode[2] = 1'b1;
    cyc(1);
    mode[2] = 1'b0;
    cyc(3);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence.
  initial begin
    mode = 5'h09;
    n_fail = 0;
    cmp_count = 0;
    do_reset();
    chk(empty_n, 1'b0, "empty");
    chk(full_n, 1'b1, "full");
    chk(half_n, 1'b1, "half");
    chk(ae_n, 1'b0, "ae");
    chk(dout, 18'h0_0000, "dout");
    chk(oe, 1'b1, "drive");
    $display("reset test done");
    foreach (ens[k]) begin
      {mode[4], mode[1:0]} = ens[k];
      cyc(1);
      chk(oe, !ens[k][2] && (!ens[k][1] || !ens[k][0]), "drive");
    end
    cyc(1);
    mode[4] = 1'b1;
    dcf_peer_inst.strobe_rd(1'b1);
    mode[4] = 1'b0;
    chk(dout, 18'h0_0000, "no oe");
    $display("drive test done");
    dcf_peer_inst.take(1'b0);
    chk(dout, 18'h0_007F, "ofs e");
    dcf_peer_inst.take(1'b0);
    chk(dout, 18'h0_007F, "ofs f");
    dcf_peer_inst.put(18'h3_C003, 1'b0);
    cyc(2);
    dcf_peer_inst.put(18'h0_0005, 1'b0);
    dcf_peer_inst.take(1'b0);
    chk(dout, 18'h0_0003, "ofs e");
    dcf_peer_inst.take(1'b0);
    chk(dout, 18'h0_0005, "ofs f");
    $display("offset test done");
    foreach (rows[i]) begin
      dcf_peer_inst.put(rows[i].d, 1'b1);
      cyc(2);
      chk(ae_n, rows[i].ae, "ae");
    end
    foreach (rows[i]) begin
      dcf_peer_inst.take(1'b1);
      chk(dout, rows[i].d, "data");
    end
    chk(empty_n, 1'b0, "drained");
    $display("data test done");
    mode[3] = 1'b0;
    rewind();
    foreach (rows[i]) begin
      dcf_peer_inst.take(1'b1);
      chk(dout, rows[i].d, "replay");
    end
    dcf_peer_inst.take(1'b1);
    chk(dout, rows[3].d, "hold");
    chk(empty_n, 1'b0, "empty");
    mode[1:0] = 2'b10;
    rewind();
    dcf_peer_inst.take(1'b1);
    chk(empty_n, 1'b0, "cascade");
    mode[1] = 1'b0;
    $display("rewind test done");
    do_reset();
    mode[3] = 1'b1;
    for (int i = 1; i <= DEP + 1; i++) begin
      dcf_peer_inst.put(18'(i), 1'b1);
      if (i == DEP / 2 || i == DEP / 2 + 1) chk(half_n, i == DEP / 2, "half");
      if (i == DEP - 128 || i == DEP - 127) chk(af_n, i == DEP - 128, "af");
      if (i == DEP - 1 || i == DEP) chk(full_n, i != DEP, "full edge");
    end
    chk(full_n, 1'b0, "full");
    chk(wr_ready, 1'b0, "ready");
    dcf_peer_inst.take(1'b1);
    chk(dout, 18'h0_0001, "first");
    $display("full test done");
    close_out();
  end
endmodule
`default_nettype wire
